/* File: hdl/sac_pkg.sv */
// constants shared by both ends of the converter link
// How it works
// - ten trials, weights 512, 256 down to one
// - set trial bit, clear it when sample below
// - sample with switches closed, open, convert, repeat
// - chip select falling edge starts a cycle from idle, completion while select is low starts the next
// - chip select fall aborts cycle, result kept
// - host keeps chip select away from completion
// - clamp result at full scale and zero
// - control inputs ignored for setup plus two ticks
// - host waits 1.425 us before first address
// - host gives rising edge within 9.5 us
// - host serial clock at most 2.1 MHz
// - four address bits msb first, first rises
// - sample from fourth fall, hold at tenth fall
package sac_pkg;
    // =========================================================
    // widths and codes
    localparam int RES_BITS = 10;
    localparam int ADDR_BITS = 4;
    localparam logic [9:0] MSB_TRIAL = 10'h200;
    localparam logic [9:0] FULL_CODE = 10'h3FF;
    localparam logic [9:0] ZERO_CODE = 10'h000;
    // =========================================================
    // serial clock edge positions
    localparam logic [4:0] ADDR_RISES = 5'h04;
    localparam logic [4:0] SAMPLE_FALL = 5'h04;
    localparam logic [4:0] HOLD_FALL = 5'h0A;
    // =========================================================
    // timing
    localparam int CLK_NS = 10;
    localparam int CS_SETUP_NS = 1425;
    localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int IO_MAX_KHZ = 2100;
    localparam int IO_MIN_PERIOD_NS = (1000000 + IO_MAX_KHZ - 1) / IO_MAX_KHZ;
    localparam int IO_HALF_CYC = (IO_MIN_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
    localparam int SLOW_RISE_NS = 9500;
    localparam int SLOW_RISE_CYC = SLOW_RISE_NS / CLK_NS;
    localparam int DEV_SETUP_NS = 500;
    localparam int DEV_SETUP_CYC = (DEV_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYS_DIV = 25;
    localparam int FILTER_TICKS = 2;
    localparam int CONV_WAIT_CYC = 400;
endpackage

/* File: hdl/sac_if.sv */
// serial link between host and converter
`timescale 1ns/10ps
interface sac_if;
    logic cs_n;
    logic io_clk;
    logic addr;
    logic data_out;
    logic data_oe;
    modport dev (input cs_n, input io_clk, input addr, output data_out, output data_oe);
    modport host (output cs_n, output io_clk, output addr, input data_out, input data_oe);
endinterface

/* File: hdl/sac_sync.sv */
// two flip-flop synchroniser
`timescale 1ns/10ps
module sac_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] m_q;
    logic [W-1:0] s_q;
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            m_q <= '0;
            s_q <= '0;
        end
        else
        begin
            m_q <= d_in;
            s_q <= m_q;
        end
    end
    assign q_out = s_q;
endmodule // sac_sync

/* File: hdl/sac_dev.sv */
// converter end: chip select sequencing and successive approximation
`timescale 1ns/10ps
module sac_dev #(
    parameter int SYS_DIV = sac_pkg::SYS_DIV
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // link
    sac_if.dev link,
    // analog side
    input wire logic cmp_below_in,
    input wire logic above_ref_in,
    input wire logic below_ref_in,
    output logic [9:0] trial_out,
    output logic sample_out,
    output logic [3:0] chan_out,
    // status
    output logic [9:0] result_out,
    output logic conv_done_out
);
    typedef enum logic [1:0] {D_IDLE, D_FILTER, D_XFER, D_CONV} sac_dstate_e;

    // =========================================================
    // input synchronisation and edges
    logic [2:0] pins_s;
    logic cs_n_s, io_s, addr_s;
    logic cs_prev_q, io_prev_q;
    logic cs_fall, io_rise, io_fall;

    sac_sync #(.W(3)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        // select enters active high so the flops reset to its idle level
        .d_in({~link.cs_n, link.io_clk, link.addr}),
        .q_out(pins_s)
    );

    assign cs_n_s = ~pins_s[2];
    assign io_s = pins_s[1];
    assign addr_s = pins_s[0];
    assign cs_fall = cs_prev_q & ~cs_n_s;
    assign io_rise = ~io_prev_q & io_s;
    assign io_fall = io_prev_q & ~io_s;

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            cs_prev_q <= 1'b1;
            io_prev_q <= 1'b0;
        end
        else
        begin
            cs_prev_q <= cs_n_s;
            io_prev_q <= io_s;
        end
    end

    // =========================================================
    // internal system clock
    logic [7:0] sys_cnt_q, sys_cnt_d;
    logic sys_tick;

    assign sys_tick = (sys_cnt_q == 8'(SYS_DIV - 1));

    always_comb
    begin
        sys_cnt_d = sys_tick ? 8'h00 : sys_cnt_q + 8'h01;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            sys_cnt_q <= 8'h00;
        else
            sys_cnt_q <= sys_cnt_d;
    end

    // =========================================================
    // sequencer
    sac_dstate_e state_q, state_d;
    logic [7:0] tmr_q, tmr_d;
    logic [4:0] rise_q, rise_d;
    logic [4:0] fall_q, fall_d;
    logic [3:0] addr_sh_q, addr_sh_d;
    logic [3:0] chan_q, chan_d;
    logic [9:0] trial_q, trial_d;
    logic [3:0] idx_q, idx_d;
    logic [9:0] result_q, result_d;
    logic [9:0] shift_q, shift_d;
    logic sample_q, sample_d;
    logic done_q, done_d;
    logic data_q, data_d;
    logic oe_q, oe_d;

    function automatic logic [9:0] bit_of(input logic [3:0] i);
        bit_of = 10'h001 << i;
    endfunction

    always_comb
    begin
        state_d = state_q;
        tmr_d = tmr_q;
        rise_d = rise_q;
        fall_d = fall_q;
        addr_sh_d = addr_sh_q;
        chan_d = chan_q;
        trial_d = trial_q;
        idx_d = idx_q;
        result_d = result_q;
        shift_d = shift_q;
        sample_d = sample_q;
        done_d = done_q;
        oe_d = ~cs_n_s;
        if ((state_q == D_XFER || state_q == D_CONV) && io_fall)
            shift_d = {shift_q[8:0], 1'b0};
        if (cs_fall)
        begin
            // a new select edge restarts from the filter state
            state_d = D_FILTER;
            tmr_d = 8'h00;
            sample_d = 1'b0;
            trial_d = sac_pkg::ZERO_CODE;
            // previous result msb stands from the start of the transfer
            shift_d = result_q;
        end
        else
        begin
            case (state_q)
                D_IDLE:
                begin
                    tmr_d = 8'h00;
                end
                D_FILTER:
                begin
                    // setup interval, then two system clock falls
                    if (tmr_q < 8'(sac_pkg::DEV_SETUP_CYC))
                        tmr_d = tmr_q + 8'h01;
                    else if (sys_tick)
                    begin
                        tmr_d = tmr_q + 8'h01;
                        if (tmr_q == 8'(sac_pkg::DEV_SETUP_CYC + sac_pkg::FILTER_TICKS - 1))
                        begin
                            state_d = D_XFER;
                            rise_d = 5'h00;
                            fall_d = 5'h00;
                            shift_d = result_q;
                        end
                    end
                    if (cs_n_s)
                        state_d = D_IDLE;
                end
                D_XFER:
                begin
                    if (cs_n_s)
                    begin
                        state_d = D_IDLE;
                        sample_d = 1'b0;
                    end
                    else
                    begin
                        if (io_rise && rise_q < sac_pkg::ADDR_RISES)
                        begin
                            addr_sh_d = {addr_sh_q[2:0], addr_s};
                            rise_d = rise_q + 5'h01;
                            if (rise_q == sac_pkg::ADDR_RISES - 5'h01)
                                chan_d = {addr_sh_q[2:0], addr_s};
                        end
                        if (io_fall)
                        begin
                            fall_d = fall_q + 5'h01;
                            if (fall_q + 5'h01 == sac_pkg::SAMPLE_FALL)
                            begin
                                sample_d = 1'b1;
                                done_d = 1'b0;
                            end
                            if (fall_q + 5'h01 == sac_pkg::HOLD_FALL)
                            begin
                                // hold the sample, open switches, start from midscale
                                sample_d = 1'b0;
                                trial_d = sac_pkg::MSB_TRIAL;
                                idx_d = 4'(sac_pkg::RES_BITS - 1);
                                state_d = D_CONV;
                            end
                        end
                    end
                end
                D_CONV:
                begin
                    if (sys_tick)
                    begin
                        if (cmp_below_in)
                            trial_d = trial_q & ~bit_of(idx_q);
                        if (idx_q == 4'h0)
                        begin
                            if (above_ref_in)
                                result_d = sac_pkg::FULL_CODE;
                            else if (below_ref_in)
                                result_d = sac_pkg::ZERO_CODE;
                            else if (cmp_below_in)
                                result_d = trial_q & ~bit_of(idx_q);
                            else
                                result_d = trial_q;
                            done_d = 1'b1;
                            // sample-then-convert begins again while select is low, else idle
                            state_d = cs_n_s ? D_IDLE : D_XFER;
                            rise_d = 5'h00;
                            fall_d = 5'h00;
                            shift_d = result_d;
                        end
                        else
                        begin
                            idx_d = idx_q - 4'h1;
                            trial_d = trial_d | bit_of(idx_q - 4'h1);
                        end
                    end
                end
                default:
                begin
                    state_d = D_IDLE;
                end
            endcase
        end
        data_d = shift_d[9];
    end


    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_q <= D_IDLE;
            tmr_q <= 8'h00;
            rise_q <= 5'h00;
            fall_q <= 5'h00;
            addr_sh_q <= 4'h0;
            chan_q <= 4'h0;
            trial_q <= 10'h000;
            idx_q <= 4'h0;
            result_q <= 10'h000;
            shift_q <= 10'h000;
            sample_q <= 1'b0;
            done_q <= 1'b0;
            data_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            addr_sh_q <= addr_sh_d;
            chan_q <= chan_d;
            trial_q <= trial_d;
            idx_q <= idx_d;
            result_q <= result_d;
            shift_q <= shift_d;
            sample_q <= sample_d;
            done_q <= done_d;
            data_q <= data_d;
            oe_q <= oe_d;
        end
    end

    assign trial_out = trial_q;
    assign sample_out = sample_q;
    assign chan_out = chan_q;
    assign result_out = result_q;
    assign conv_done_out = done_q;
    assign link.data_out = data_q;
    assign link.data_oe = oe_q;
endmodule // sac_dev

/* File: hdl/sac_host.sv */
// host end: serial port that selects a channel and reads the result
`timescale 1ns/10ps
module sac_host #(
    parameter int N_CLKS = 16,
    parameter int CONV_WAIT = sac_pkg::CONV_WAIT_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // link
    sac_if.host link,
    // user side
    input wire logic start_in,
    input wire logic [3:0] chan_in,
    output logic busy_out,
    output logic [9:0] result_out,
    output logic result_valid_out
);
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_CLK, H_GAP} sac_hstate_e;

    logic data_s;

    sac_sync #(.W(1)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .d_in(link.data_out),
        .q_out(data_s)
    );

    // =========================================================
    // sequencer
    sac_hstate_e state_q, state_d;
    logic [11:0] tmr_q, tmr_d;
    logic [4:0] edge_q, edge_d;
    logic [3:0] addr_q, addr_d;
    logic [9:0] rx_q, rx_d;
    logic [9:0] res_q, res_d;
    logic cs_n_q, cs_n_d;
    logic clk_q, clk_d;
    logic a_q, a_d;
    logic valid_q, valid_d;

    always_comb
    begin
        state_d = state_q;
        tmr_d = tmr_q + 12'h001;
        edge_d = edge_q;
        addr_d = addr_q;
        rx_d = rx_q;
        res_d = res_q;
        cs_n_d = cs_n_q;
        clk_d = clk_q;
        a_d = a_q;
        valid_d = 1'b0;
        case (state_q)
            H_IDLE:
            begin
                tmr_d = 12'h000;
                if (start_in)
                begin
                    state_d = H_SETUP;
                    cs_n_d = 1'b0;
                    addr_d = {chan_in[2:0], 1'b0};
                    a_d = chan_in[3];
                    edge_d = 5'h00;
                end
            end
            H_SETUP:
            begin
                if (tmr_q == 12'(sac_pkg::CS_SETUP_CYC - 1))
                begin
                    state_d = H_CLK;
                    tmr_d = 12'h000;
                end
            end
            H_CLK:
            begin
                // half period fixed at the fastest legal rate
                if (tmr_q == 12'(sac_pkg::IO_HALF_CYC - 1))
                begin
                    tmr_d = 12'h000;
                    clk_d = ~clk_q;
                    if (!clk_q)
                    begin
                        if (edge_q < 5'(sac_pkg::RES_BITS))
                            rx_d = {rx_q[8:0], data_s};
                    end
                    else
                    begin
                        edge_d = edge_q + 5'h01;
                        a_d = addr_q[3];
                        addr_d = {addr_q[2:0], 1'b0};
                        if (edge_q == 5'(N_CLKS - 1))
                        begin
                            state_d = H_GAP;
                            cs_n_d = 1'b1;
                            res_d = rx_q;
                            valid_d = 1'b1;
                        end
                    end
                end
            end
            H_GAP:
            begin
                // keep select high until the conversion is surely over
                if (tmr_q == 12'(CONV_WAIT - 1))
                    state_d = H_IDLE;
            end
            default:
            begin
                state_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_q <= H_IDLE;
            tmr_q <= 12'h000;
            edge_q <= 5'h00;
            addr_q <= 4'h0;
            rx_q <= 10'h000;
            res_q <= 10'h000;
            cs_n_q <= 1'b1;
            clk_q <= 1'b0;
            a_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            edge_q <= edge_d;
            addr_q <= addr_d;
            rx_q <= rx_d;
            res_q <= res_d;
            cs_n_q <= cs_n_d;
            clk_q <= clk_d;
            a_q <= a_d;
            valid_q <= valid_d;
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.io_clk = clk_q;
    assign link.addr = a_q;
    assign busy_out = (state_q != H_IDLE);
    assign result_out = res_q;
    assign result_valid_out = valid_q;
endmodule // sac_host

/* File: sim/sac_properties.sv */
// concurrent checks on the host-to-converter link
`timescale 1ns/10ps
module sac_properties (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // link
    input wire logic cs_n,
    input wire logic data_out,
    input wire logic data_oe,
    // converter side
    input wire logic above_ref_in,
    input wire logic below_ref_in,
    input wire logic [9:0] trial_out,
    input wire logic sample_out,
    input wire logic [9:0] result_out,
    input wire logic conv_done_out
);
    // ========================================================
    // helpers: sampling span and previous trial
    logic [9:0] span_q;
    logic [9:0] span_d;
    logic [9:0] trial_q;
    logic [9:0] trial_d;
    logic [9:0] low_bit;
    always_comb
    begin
        span_d = (sample_out && !rst_in) ? span_q + 10'h001 : 10'h000;
        trial_d = rst_in ? 10'h000 : trial_out;
        low_bit = trial_q & (~trial_q + 10'h001);
    end
    always_ff @(posedge core_clk_in)
    begin
        span_q <= span_d;
        trial_q <= trial_d;
    end
    // ========================================================
    // properties
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:5] data_oe)
        else $error("data output not enabled after select");
    a_oe_off_release: assert property ($rose(cs_n) |-> ##[1:5] !data_oe)
        else $error("data output still enabled after release");
    a_filter_quiet: assert property ($fell(cs_n) |=> !sample_out [*8])
        else $error("sampling during select filter");
    a_hold_from_msb: assert property ($fell(sample_out) |-> ##[0:2] trial_out == sac_pkg::MSB_TRIAL)
        else $error("conversion did not start at top trial");
    a_sample_span: assert property ($fell(sample_out) |-> span_q inside {[10'h11C:10'h124]})
        else $error("sampling span not six serial periods");
    a_trial_step: assert property ((trial_out != trial_q) && trial_q != 10'h000 && trial_out != 10'h000
        && trial_out != sac_pkg::MSB_TRIAL |->
        (trial_out & ~low_bit) == ((trial_q & ~low_bit) | (low_bit >> 1)))
        else $error("trial step wrong");
    a_done_latches: assert property ($rose(conv_done_out) |-> result_out == (above_ref_in ?
        sac_pkg::FULL_CODE : (below_ref_in ? sac_pkg::ZERO_CODE : trial_out)))
        else $error("latched result differs from final trial");
    a_result_held: assert property ($changed(result_out) |-> $rose(conv_done_out))
        else $error("result changed without completion");
    a_first_bit_msb: assert property ($rose(data_oe) |-> data_out == result_out[9])
        else $error("first data bit is not previous result msb");
    c_full: cover property ($rose(conv_done_out) && above_ref_in);
    c_zero: cover property ($rose(conv_done_out) && below_ref_in && !above_ref_in);
    c_hold: cover property ($fell(sample_out));
endmodule // sac_properties

/* File: sim/sar_conversion_and_select_control_tb.sv */
// bench: host and converter joined, plus a converter driven by the bench
`timescale 1ns/10ps
module sar_conversion_and_select_control_tb;
    // ========================================================
    // signals and instances
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    logic [3:0] chan_in = 4'h0;
    logic cmp_a = 1'b0;
    logic cmp_b = 1'b0;
    logic above = 1'b0;
    logic below = 1'b0;
    logic [9:0] tgt_a = 10'h000;
    logic [9:0] tgt_b = 10'h000;
    logic [9:0] last_res = 10'h000;
    logic io_gen = 1'b0;
    logic b_cs_n = 1'b1;
    logic b_io = 1'b0;
    logic b_addr = 1'b0;
    logic busy, valid, a_sample, b_sample, a_done, b_done;
    logic [9:0] h_result, a_trial, a_result, b_trial, b_result;
    logic [3:0] a_chan, b_chan;
    int failures = 0;
    int checks_done = 0;
    sac_if link_a();
    sac_if link_b();
    assign link_b.cs_n = b_cs_n;
    assign link_b.io_clk = b_io;
    assign link_b.addr = b_addr;
    always #5 core_clk_in = ~core_clk_in;
    always #62.5 io_gen = ~io_gen;
    always @(negedge core_clk_in)
    begin
        cmp_a <= tgt_a < a_trial;
        cmp_b <= tgt_b < b_trial;
    end
    sac_host u_sac_host (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(link_a.host), .start_in(start_in),
        .chan_in(chan_in), .busy_out(busy), .result_out(h_result), .result_valid_out(valid));
    sac_dev u_sac_dev (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(link_a.dev), .cmp_below_in(cmp_a),
        .above_ref_in(above), .below_ref_in(below), .trial_out(a_trial), .sample_out(a_sample),
        .chan_out(a_chan), .result_out(a_result), .conv_done_out(a_done));
    sac_dev u_sac_dev_b (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(link_b.dev), .cmp_below_in(cmp_b),
        .above_ref_in(1'b0), .below_ref_in(1'b0), .trial_out(b_trial), .sample_out(b_sample),
        .chan_out(b_chan), .result_out(b_result), .conv_done_out(b_done));
    sac_properties u_sac_properties (.core_clk_in(core_clk_in), .rst_in(rst_in), .cs_n(link_a.cs_n),
        .data_out(link_a.data_out), .data_oe(link_a.data_oe), .above_ref_in(above), .below_ref_in(below),
        .trial_out(a_trial), .sample_out(a_sample), .result_out(a_result), .conv_done_out(a_done));
    // ========================================================
    // wire monitor: bits seen on serial clock rises
    logic io_seen = 1'b0;
    int rise_n = 0;
    logic [9:0] rd_bits = 10'h000;
    logic [3:0] ad_bits = 4'h0;
    always @(posedge core_clk_in)
    begin
        io_seen <= link_a.io_clk;
        if (link_a.cs_n)
            rise_n <= 0;
        else if (link_a.io_clk && !io_seen)
        begin
            rise_n <= rise_n + 1;
            if (rise_n < 10)
                rd_bits <= {rd_bits[8:0], link_a.data_out};
            if (rise_n < 4)
                ad_bits <= {ad_bits[2:0], link_a.addr};
        end
    end
    // ========================================================
    // tasks
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run_convert(input logic [3:0] ch, input logic [9:0] tg, input logic up, input logic dn);
        logic [9:0] exp;
        int n;
        exp = up ? sac_pkg::FULL_CODE : (dn ? sac_pkg::ZERO_CODE : tg);
        @(negedge core_clk_in);
        tgt_a = tg;
        above = up;
        below = dn;
        chan_in = ch;
        start_in = 1'b1;
        @(negedge core_clk_in);
        start_in = 1'b0;
        for (n = 0; n < 3000 && valid !== 1'b1; n++)
            @(negedge core_clk_in);
        chk({9'h000, valid}, 10'h001, "result valid");
        chk(h_result, last_res, "host result");
        chk(rd_bits, last_res, "data bits on wire");
        chk({6'h00, ad_bits}, {6'h00, ch}, "address bits on wire");
        for (n = 0; n < 3000 && busy !== 1'b0; n++)
            @(negedge core_clk_in);
        chk(a_result, exp, "converted code");
        chk({6'h00, a_chan}, {6'h00, ch}, "captured channel");
        chk({9'h000, a_done}, 10'h001, "done flag");
        last_res = exp;
    endtask
    // early pulses fall inside the select filter and must be ignored
    task automatic drive_frame(input logic [3:0] ch, input int early);
        int i;
        // every pin change waits for a falling core edge to stay off the sampling edge
        @(negedge io_gen) @(negedge core_clk_in) b_cs_n = 1'b0;
        b_addr = ~ch[3];
        for (i = 0; i < early; i++)
        begin
            @(posedge io_gen) @(negedge core_clk_in) b_io = 1'b1;
            @(negedge io_gen) @(negedge core_clk_in) b_io = 1'b0;
        end
        repeat (150) @(negedge core_clk_in);
        for (i = 0; i < 10; i++)
        begin
            @(negedge io_gen) @(negedge core_clk_in) b_addr = (i < 4) ? ch[3 - i] : 1'b0;
            @(posedge io_gen) @(negedge core_clk_in) b_io = 1'b1;
            @(negedge io_gen) @(negedge core_clk_in) b_io = 1'b0;
        end
        repeat (5) @(negedge core_clk_in);
        b_cs_n = 1'b1;
        b_addr = ~b_addr;
    endtask
    task automatic run_abort;
        tgt_b = 10'h1C7;
        drive_frame(4'h9, 3);
        repeat (400) @(negedge core_clk_in);
        chk(b_result, 10'h1C7, "ten clock conversion");
        chk({6'h00, b_chan}, 10'h009, "channel after filter");
        tgt_b = 10'h03C;
        drive_frame(4'h2, 0);
        repeat (40) @(negedge core_clk_in);
        b_cs_n = 1'b0;
        repeat (10) @(negedge core_clk_in);
        chk(b_trial, 10'h000, "trial after abort");
        chk({9'h000, b_sample}, 10'h000, "switches after abort");
        repeat (400) @(negedge core_clk_in);
        chk(b_result, 10'h1C7, "result kept on abort");
        chk({9'h000, b_done}, 10'h000, "no done on abort");
        b_cs_n = 1'b1;
        repeat (10) @(negedge core_clk_in);
        tgt_b = 10'h2E1;
        drive_frame(4'h4, 0);
        repeat (400) @(negedge core_clk_in);
        chk(b_result, 10'h2E1, "conversion after abort");
    endtask
    // ========================================================
    // main sequence and watchdog
    initial
    begin
        repeat (3) @(negedge core_clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        run_convert(4'h3, 10'h2AA, 1'b0, 1'b0);
        run_convert(4'hA, 10'h155, 1'b0, 1'b0);
        run_convert(4'hD, 10'h3FF, 1'b0, 1'b0);
        run_convert(4'h0, 10'h000, 1'b0, 1'b0);
        run_convert(4'h5, 10'h123, 1'b1, 1'b0);
        run_convert(4'h6, 10'h2AA, 1'b0, 1'b1);
        run_convert(4'hF, 10'h0F0, 1'b1, 1'b1);
        run_convert(4'h1, 10'h201, 1'b0, 1'b0);
        run_abort();
        close_out();
    end
    initial
    begin
        repeat (40000) @(posedge core_clk_in);
        failures++;
        close_out();
    end
endmodule // sar_conversion_and_select_control_tb
